// ==== ibr_axil_slave.sv ====
// ibr_axil_slave: AXI4-Lite channel handling with one write and one read in flight
`timescale 1ns/1ps
`default_nettype none
module ibr_axil_slave
  import ibr_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data
  input wire logic [AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [DW-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read channels
  input wire logic [AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [DW-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register file side
  output logic wr_en,
  output logic [AXI_AW-1:0] wr_addr,
  output logic [DW-1:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic [AXI_AW-1:0] rd_addr,
  input wire logic [DW-1:0] rd_data,
  input wire logic rd_err
);
  logic aw_got_r, w_got_r;
  // ==========================================================
  // address and data are taken in either order, then applied together
  assign awready = !aw_got_r && !bvalid;
  assign wready = !w_got_r && !bvalid;
  assign wr_en = aw_got_r && w_got_r;
  assign arready = !rvalid;
  assign rd_addr = araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      wr_addr <= '0;
    end else if (wr_en) begin
      aw_got_r <= 1'b0;
    end else if (awvalid && awready) begin
      aw_got_r <= 1'b1;
      wr_addr <= awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_r <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (wr_en) begin
      w_got_r <= 1'b0;
    end else if (wvalid && wready) begin
      w_got_r <= 1'b1;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // read data is captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_data;
      rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule : ibr_axil_slave
`default_nettype wire

// ==== ibr_decode.sv ====
// ibr_decode: indirect/relative branch, branch-with-transfer and return decode
// Overview of operation
// - an omitted condition means always true; the branch is unconditional
// - the else bit runs compute with the branch or only on false path
// - branch type bit picks jump or call; call ignores loop abort and clear
// - delay bit picks delayed or non-delayed branch
// - relative target is pc plus sign-extended 6-bit offset
// - indirect target is index plus modify, index left unchanged
// - zero compute field means no compute operation
// - transfer jump is conditional; false path does memory transfer and compute
// - transfer jump is never delayed, never aborts loops, never clears interrupts
// - transfer addresses with data index, then post-modifies and writes back
// - direction bit picks read or write; register field names the location
// - in dual mode the branch needs the condition true in both elements
// - in dual mode each element does its else work on its own false
// - x element uses the named register, y element its complement
// - in dual mode y addresses x index plus one
// - broadcast read loads the same word into both elements
// - top bits 110 mark the indirect transfer jump with its field order
// - top bits 111 mark the relative form, offset replacing branch selectors
// - returns branch to pc stack top and pop it
// - interrupt return also pops status stack for status-pushing interrupts
// - interrupt return clears serviced bit in latch and mask pointer
// - subroutine return takes delay and reentry; interrupt return only delay
// - loop abort on a jump pops loop stacks and pc stack
// - clear-interrupt jump clears current bit in latch and mask pointer
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ibr_decode
  import ibr_pkg::*;
#(
  parameter int IRQ_N = 16,
  parameter logic [31:0] STAT_PUSH_MASK = 32'h0000_00FF
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [DW-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [DW-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // instruction and sequencer state
  input wire logic instr_valid,
  input wire logic [IW-1:0] instr_word,
  input wire logic [DW-1:0] pc_cur,
  input wire logic [DW-1:0] pc_stack_top,
  input wire logic [15:0] x_flags,
  input wire logic [15:0] y_flags,
  // interrupt unit
  input wire logic [IRQ_N-1:0] irq_raise,
  input wire logic [IRQ_N-1:0] irq_enter,
  input wire logic [4:0] irq_serviced_idx,
  // sequencer commands
  output logic branch_take,
  output logic [DW-1:0] branch_target,
  output logic branch_delayed,
  output logic branch_call,
  output logic pc_stack_pop,
  output logic loop_stack_pop,
  output logic status_stack_pop,
  output logic loop_reentry,
  // data memory and register file
  output logic dm_x_en,
  output logic dm_y_en,
  output logic dm_write,
  output logic [DW-1:0] dm_x_addr,
  output logic [DW-1:0] dm_y_addr,
  output logic [4:0] rf_x_sel,
  output logic [4:0] rf_y_sel,
  output logic rf_y_bcast,
  // compute slot
  output logic cmp_x_en,
  output logic cmp_y_en,
  output logic [CMP_W-1:0] cmp_word
);
  if (IRQ_N < 1 || IRQ_N > 32) begin : g_chk
    $error("IRQ_N must lie between 1 and 32");
  end

  // ==========================================================
  // register bus front end
  logic wr_en, wr_err, rd_err;
  logic [AXI_AW-1:0] wr_addr, rd_addr;
  logic [DW-1:0] wr_data, rd_data;
  logic [3:0] wr_strb;

  ibr_axil_slave u_bus (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb),
    .wr_err(wr_err), .rd_addr(rd_addr), .rd_data(rd_data), .rd_err(rd_err)
  );

  function automatic logic in_bank(input logic [AXI_AW-1:0] a, input logic [AXI_AW-1:0] base);
    return a[7:6] == base[7:6];
  endfunction : in_bank

  function automatic logic is_reg(input logic [AXI_AW-1:0] a, input logic [AXI_AW-1:0] r);
    return a[7:2] == r[7:2];
  endfunction : is_reg

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] nw,
                                          input logic [3:0] strb);
    logic [DW-1:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // ==========================================================
  // software-visible state
  logic [DW-1:0] mode_r, tgt_r;
  logic [IRQ_N-1:0] latch_r, maskp_r;
  logic [4:0] stat_r;
  logic [DW-1:0] idx_r [NREG];
  logic [DW-1:0] mod_r [NREG];
  logic simd, bcast;

  assign simd = mode_r[MODE_SIMD_BIT];
  assign bcast = mode_r[MODE_BCAST_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= MODE_RST;
    end else if (wr_en && is_reg(wr_addr, REG_MODE)) begin
      mode_r <= merge(mode_r, wr_data, wr_strb);
    end
  end

  // status and last-target are read-only, writing them earns an error
  assign wr_err = !(is_reg(wr_addr, REG_MODE) || is_reg(wr_addr, REG_LATCH) ||
                    is_reg(wr_addr, REG_MASKP) || in_bank(wr_addr, REG_IDX_BASE) ||
                    in_bank(wr_addr, REG_MOD_BASE));

  always_comb begin
    rd_data = '0;
    rd_err = 1'b0;
    if (in_bank(rd_addr, REG_IDX_BASE)) begin
      rd_data = idx_r[rd_addr[5:2]];
    end else if (in_bank(rd_addr, REG_MOD_BASE)) begin
      rd_data = mod_r[rd_addr[5:2]];
    end else if (is_reg(rd_addr, REG_MODE)) begin
      rd_data = mode_r;
    end else if (is_reg(rd_addr, REG_LATCH)) begin
      rd_data[IRQ_N-1:0] = latch_r;
    end else if (is_reg(rd_addr, REG_MASKP)) begin
      rd_data[IRQ_N-1:0] = maskp_r;
    end else if (is_reg(rd_addr, REG_STAT)) begin
      rd_data[4:0] = stat_r;
    end else if (is_reg(rd_addr, REG_TGT)) begin
      rd_data = tgt_r;
    end else begin
      rd_err = 1'b1;
    end
  end

  // ==========================================================
  // instruction classification
  ibr_kind_t kind;
  logic is_rel, is_rti, x_true, y_true, br_ok, x_alt, y_alt, has_cmp, bc_rd;
  logic [4:0] test_condition_code_code;
  logic [DW-1:0] sext, br_tgt, x_addr;
  logic [3:0] data_index_sel, data_modify_sel;

  always_comb begin
    kind = INS_NONE;
    if (instr_valid) begin
      if (instr_word[47:45] == OP10_IND || instr_word[47:45] == OP10_REL) begin
        kind = INS_T10;
      end else if (instr_word[47:40] == OP9_IND || instr_word[47:40] == OP9_REL) begin
        kind = INS_T9;
      end else if (instr_word[47:40] == OP11_RTS || instr_word[47:40] == OP11_RTI) begin
        kind = INS_T11;
      end
    end
  end

  assign is_rel = (kind == INS_T10) ? instr_word[45] : instr_word[40];
  assign is_rti = instr_word[40];
  assign test_condition_code_code = instr_word[F_TEST_CONDITION_CODE_LO +: 5];
  assign has_cmp = |instr_word[CMP_W-1:0];
  assign data_index_sel = {1'b0, instr_word[F_DMI_LO +: 3]};
  assign data_modify_sel = {1'b0, instr_word[F_DMM_LO +: 3]};
  assign x_addr = idx_r[data_index_sel];

  ibr_test_condition_code_eval u_test_condition_code_x (.test_condition_code_code(test_condition_code_code), .flags(x_flags), .test_condition_code_true(x_true));
  ibr_test_condition_code_eval u_test_condition_code_y (.test_condition_code_code(test_condition_code_code), .flags(y_flags), .test_condition_code_true(y_true));

  assign br_ok = simd ? (x_true && y_true) : x_true;
  assign x_alt = !x_true;
  assign y_alt = simd && !y_true;
  assign bc_rd = bcast && !instr_word[F_D] && x_alt;
  assign sext = {{(DW-6){instr_word[F_REL_LO+5]}}, instr_word[F_REL_LO +: 6]};

  // branch selectors live in the second generator bank, so the index is offset by 8
  always_comb begin
    if (kind == INS_T11) begin
      br_tgt = pc_stack_top;
    end else if (is_rel) begin
      br_tgt = pc_cur + sext;
    end else begin
      br_tgt = idx_r[{1'b1, instr_word[F_PMI_LO +: 3]}] + mod_r[{1'b1, instr_word[F_PMM_LO +: 3]}];
    end
  end

  // ==========================================================
  // next values of the command outputs
  logic take_nxt, dly_nxt, call_nxt, pcpop_nxt, lpop_nxt, spop_nxt, lr_nxt, irq_clr;
  logic mx_nxt, my_nxt, cx_nxt, cy_nxt, upd;

  always_comb begin
    take_nxt = 1'b0;
    dly_nxt = 1'b0;
    call_nxt = 1'b0;
    pcpop_nxt = 1'b0;
    lpop_nxt = 1'b0;
    spop_nxt = 1'b0;
    lr_nxt = 1'b0;
    irq_clr = 1'b0;
    mx_nxt = 1'b0;
    my_nxt = 1'b0;
    cx_nxt = 1'b0;
    cy_nxt = 1'b0;
    upd = 1'b0;
    case (kind)
      INS_T9: begin
        take_nxt = br_ok;
        call_nxt = instr_word[F_B];
        dly_nxt = instr_word[F_J];
        lpop_nxt = br_ok && !instr_word[F_B] && instr_word[F_A];
        pcpop_nxt = lpop_nxt;
        irq_clr = br_ok && !instr_word[F_B] && instr_word[F_CI];
        cx_nxt = has_cmp && (instr_word[F_E] ? !x_true : x_true);
        cy_nxt = has_cmp && simd && (instr_word[F_E] ? !y_true : y_true);
      end
      INS_T10: begin
        take_nxt = br_ok;
        mx_nxt = x_alt;
        my_nxt = y_alt || bc_rd;
        cx_nxt = has_cmp && x_alt;
        cy_nxt = has_cmp && y_alt;
        upd = x_alt || y_alt;
      end
      INS_T11: begin
        take_nxt = br_ok;
        dly_nxt = instr_word[F_J];
        pcpop_nxt = br_ok;
        lr_nxt = br_ok && !is_rti && instr_word[F_LR];
        spop_nxt = br_ok && is_rti && STAT_PUSH_MASK[irq_serviced_idx];
        irq_clr = br_ok && is_rti;
        cx_nxt = has_cmp && (instr_word[F_E] ? !x_true : x_true);
        cy_nxt = has_cmp && simd && (instr_word[F_E] ? !y_true : y_true);
      end
      default: begin
        take_nxt = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // sequencer and datapath command registers, one cycle per instruction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      branch_take <= 1'b0;
      branch_target <= '0;
      branch_delayed <= 1'b0;
      branch_call <= 1'b0;
      pc_stack_pop <= 1'b0;
      loop_stack_pop <= 1'b0;
      status_stack_pop <= 1'b0;
      loop_reentry <= 1'b0;
    end else begin
      branch_take <= take_nxt;
      branch_target <= br_tgt;
      branch_delayed <= dly_nxt;
      branch_call <= call_nxt;
      pc_stack_pop <= pcpop_nxt;
      loop_stack_pop <= lpop_nxt;
      status_stack_pop <= spop_nxt;
      loop_reentry <= lr_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dm_x_en <= 1'b0;
      dm_y_en <= 1'b0;
      dm_write <= 1'b0;
      dm_x_addr <= '0;
      dm_y_addr <= '0;
      rf_x_sel <= '0;
      rf_y_sel <= '0;
      rf_y_bcast <= 1'b0;
      cmp_x_en <= 1'b0;
      cmp_y_en <= 1'b0;
      cmp_word <= '0;
    end else begin
      dm_x_en <= mx_nxt;
      dm_y_en <= my_nxt;
      dm_write <= instr_word[F_D];
      dm_x_addr <= x_addr;
      dm_y_addr <= bc_rd ? x_addr : x_addr + 32'h0000_0001;
      rf_x_sel <= {1'b0, instr_word[F_DREG_LO +: 4]};
      rf_y_sel <= {1'b1, instr_word[F_DREG_LO +: 4]};
      rf_y_bcast <= bc_rd && (kind == INS_T10);
      cmp_x_en <= cx_nxt;
      cmp_y_en <= cy_nxt;
      cmp_word <= instr_word[CMP_W-1:0];
    end
  end

  // post-modify write-back wins over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < NREG; k++) begin
        idx_r[k] <= '0;
      end
    end else begin
      if (wr_en && in_bank(wr_addr, REG_IDX_BASE)) begin
        idx_r[wr_addr[5:2]] <= merge(idx_r[wr_addr[5:2]], wr_data, wr_strb);
      end
      if (upd) begin
        idx_r[data_index_sel] <= x_addr + mod_r[data_modify_sel];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < NREG; k++) begin
        mod_r[k] <= '0;
      end
    end else if (wr_en && in_bank(wr_addr, REG_MOD_BASE)) begin
      mod_r[wr_addr[5:2]] <= merge(mod_r[wr_addr[5:2]], wr_data, wr_strb);
    end
  end

  // ==========================================================
  // interrupt latch and mask pointer; a new event beats a clear
  logic [IRQ_N-1:0] clr_vec;
  logic [DW-1:0] latch_sw, maskp_sw;

  // the bus word is built at full width, then cut back to the implemented interrupt count
  assign latch_sw = (wr_en && is_reg(wr_addr, REG_LATCH)) ?
                    merge(DW'(latch_r), wr_data, wr_strb) : DW'(latch_r);
  assign maskp_sw = (wr_en && is_reg(wr_addr, REG_MASKP)) ?
                    merge(DW'(maskp_r), wr_data, wr_strb) : DW'(maskp_r);

  for (genvar i = 0; i < IRQ_N; i++) begin : g_clr
    assign clr_vec[i] = irq_clr && (irq_serviced_idx == 5'(i));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_r <= LATCH_RST[IRQ_N-1:0];
    end else begin
      latch_r <= (latch_sw[IRQ_N-1:0] & ~clr_vec) | irq_raise;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      maskp_r <= MASKP_RST[IRQ_N-1:0];
    end else begin
      maskp_r <= (maskp_sw[IRQ_N-1:0] & ~clr_vec) | irq_enter;
    end
  end

  // status shows the last decoded group and outcome
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_r <= '0;
      tgt_r <= '0;
    end else if (kind != INS_NONE) begin
      stat_r <= {kind, y_alt, x_alt, br_ok};
      if (br_ok) begin
        tgt_r <= br_tgt;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_t9_always;
    kind == INS_T9 && test_condition_code_code == TEST_CONDITION_CODE_ALWAYS;
  endsequence
  sequence s_t10;
    kind == INS_T10;
  endsequence
  sequence s_rti_taken;
    kind == INS_T11 && is_rti && br_ok;
  endsequence

  a_uncond_branch: assert property (s_t9_always |=> branch_take)
    else $error("omitted condition did not branch");
  a_else_compute: assert property (kind == INS_T9 && instr_word[F_E] && x_true |=> !cmp_x_en)
    else $error("else compute ran on true path");
  a_call_ignores: assert property (kind == INS_T9 && instr_word[F_B] |=> branch_call && !loop_stack_pop)
    else $error("call acted on loop abort");
  a_rel_target: assert property (kind == INS_T9 && is_rel
                                 |=> branch_target == $past(pc_cur) + $past(sext))
    else $error("relative target wrong");
  a_xfer_plain: assert property (s_t10 |=> !branch_delayed && !loop_stack_pop && !branch_call)
    else $error("transfer jump carried a modifier");
  a_xfer_else: assert property (s_t10 |=> dm_x_en == !branch_take || $past(simd))
    else $error("transfer and jump not exclusive");
  a_dual_and: assert property (simd && kind != INS_NONE && !(x_true && y_true) |=> !branch_take)
    else $error("dual branch without both true");
  a_y_address: assert property (dm_y_en && !rf_y_bcast |-> dm_y_addr == dm_x_addr + 32'h0000_0001)
    else $error("y address not x plus one");
  a_bcast_same: assert property (rf_y_bcast |-> dm_y_en && !dm_write && dm_y_addr == dm_x_addr)
    else $error("broadcast read mismatch");
  a_return_pop: assert property (kind == INS_T11 && br_ok
                                 |=> pc_stack_pop && branch_target == $past(pc_stack_top))
    else $error("return did not pop to stack top");
  a_irq_cleared: assert property (s_rti_taken
                                  |=> (latch_r & $past(clr_vec & ~irq_raise)) == '0)
    else $error("serviced latch bit not cleared");
  a_rti_no_lr: assert property (kind == INS_T11 && is_rti |=> !loop_reentry)
    else $error("interrupt return took reentry");
endmodule : ibr_decode
`default_nettype wire

// ==== ibr_decode_tb_top.sv ====
// ibr_decode_tb_top: self-checking bench for the program-flow decode block
`timescale 1ns/1ps
`default_nettype none
module ibr_decode_tb_top;
  import ibr_pkg::*;
  // ==========================================
  // stimulus and observed signals
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, instr_valid = 0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, pc_cur = '0;
  logic [3:0] wstrb = 4'hF;
  logic [47:0] instr_word = '0;
  logic [15:0] x_flags = '0, y_flags = '0, irq_raise = '0, irq_enter = '0;
  logic [4:0] irq_serviced_idx = '0;
  logic awready, wready, bvalid, arready, rvalid, branch_take, branch_delayed, branch_call, pc_stack_pop;
  logic loop_stack_pop, status_stack_pop, loop_reentry, dm_x_en, dm_y_en, dm_write, rf_y_bcast, cmp_x_en, cmp_y_en;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, branch_target, dm_x_addr, dm_y_addr, pc_stack_top, rd_v;
  logic [4:0] rf_x_sel, rf_y_sel;
  logic [22:0] cmp_word;
  int fail_count = 0;
  int comparisons = 0;
  ibr_decode dut (.*);
  ibr_stack_model u_stk (.*);
  always #5 aclk = ~aclk;
  // ==========================================
  // shared tasks
  task automatic give_verdict;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // levels are judged mid-cycle, so the next rising edge is the handshake; a long wait ends the run
  task automatic tick(inout int n);
    @(negedge aclk);
    n++;
    if (n > 64) begin
      fail_count++;
      give_verdict();
    end
  endtask : tick
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    logic aw_on = 1'b1, w_on = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_on || w_on) begin
      tick(n);
      aw_on = aw_on && !awready;
      w_on = w_on && !wready;
      @(posedge aclk);
      awvalid <= aw_on;
      wvalid <= w_on;
    end
    do begin
      tick(n);
    end while (!bvalid);
    @(posedge aclk);
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      tick(n);
    end while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do begin
      tick(n);
    end while (!rvalid);
    rd_v = rdata;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : axr
  task automatic issue(input logic [47:0] w, input logic [15:0] xf = '0, input logic [15:0] yf = '0);
    @(posedge aclk);
    instr_word <= w;
    instr_valid <= 1'b1;
    x_flags <= xf;
    y_flags <= yf;
    @(posedge aclk);
    instr_valid <= 1'b0;
    #1;
  endtask : issue
  // ==========================================
  // scenarios
  task automatic t_jump;
    axw(REG_IDX_BASE + 8'h20, 32'h100);
    axw(REG_MOD_BASE + 8'h20, 32'h10);
    issue({OP9_IND, 2'b00, TEST_CONDITION_CODE_ALWAYS, 3'h0, 3'h0, 3'b000, 24'h0});
    chk("take", 1, branch_take);
    chk("target", 32'h110, branch_target);
    chk("delayed", 0, branch_delayed);
    chk("call", 0, branch_call);
    axr(REG_IDX_BASE + 8'h20);
    chk("index", 32'h100, rd_v);
  endtask : t_jump
  task automatic t_xfer;
    axw(REG_IDX_BASE, 32'h20);
    axw(REG_MOD_BASE, 32'h4);
    issue({OP10_IND, 1'b1, 6'h00, 5'h00, 6'h00, 4'h3, 23'h0});
    chk("take", 0, branch_take);
    chk("dm_x_en", 1, dm_x_en);
    chk("dm_x_addr", 32'h20, dm_x_addr);
    chk("dm_write", 1, dm_write);
    chk("rf_x_sel", 5'h03, rf_x_sel);
    chk("cmp_x_en", 0, cmp_x_en);
    axr(REG_IDX_BASE);
    chk("index", 32'h24, rd_v);
  endtask : t_xfer
  task automatic t_ret;
    axw(REG_LATCH, 32'h1);
    issue({OP11_RTS, 2'b00, TEST_CONDITION_CODE_ALWAYS, 8'h00, 1'b1, 24'h0});
    chk("target", 32'h100, branch_target);
    chk("reentry", 1, loop_reentry);
    chk("pc_pop", 1, pc_stack_pop);
    chk("stat_pop", 0, status_stack_pop);
    issue({OP11_RTI, 2'b00, TEST_CONDITION_CODE_ALWAYS, 33'h0});
    chk("target", 32'h101, branch_target);
    chk("stat_pop", 1, status_stack_pop);
    axr(REG_LATCH);
    chk("latch", 0, rd_v);
    axr(8'hFC);
    chk("rresp", RESP_SLVERR, rresp);
  endtask : t_ret
  // index 0 starts at 24 and steps by modify 0 (4) after each transfer
  task automatic t_dual;
    logic [47:0] w;
    w = {OP10_IND, 1'b0, 3'h0, 3'h0, 5'h00, 3'h0, 3'h0, 4'h5, 23'h1};
    axw(REG_MODE, 32'h1);
    issue(w, 16'h0, 16'h1);
    chk("dm_x_en", 1, dm_x_en);
    chk("dm_y_en", 0, dm_y_en);
    chk("cmp_y_en", 0, cmp_y_en);
    chk("cmp_word", 1, cmp_word);
    issue(w, 16'h1, 16'h0);
    chk("take", 0, branch_take);
    chk("dm_y_addr", 32'h29, dm_y_addr);
    chk("rf_y_sel", 5'h15, rf_y_sel);
    chk("cmp_y_en", 1, cmp_y_en);
    axw(REG_MODE, 32'h2);
    issue(w);
    chk("bcast", 1, rf_y_bcast);
    chk("dm_y_addr", 32'h2C, dm_y_addr);
    issue({OP9_IND, 2'b01, TEST_CONDITION_CODE_ALWAYS, 9'h000, 24'h0});
    chk("loop_pop", 1, loop_stack_pop);
    chk("pc_pop", 1, pc_stack_pop);
  endtask : t_dual
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_jump();
    t_xfer();
    t_ret();
    t_dual();
    give_verdict();
  end
endmodule : ibr_decode_tb_top
`default_nettype wire

// ==== ibr_pkg.sv ====
// ibr_pkg: shared constants and types for the program-flow decode block
package ibr_pkg;
  // ==========================================================
  // widths
  localparam int AXI_AW = 8;
  localparam int DW = 32;
  localparam int IW = 48;
  localparam int NREG = 16;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_LATCH = 8'h04;
  localparam logic [7:0] REG_MASKP = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_TGT = 8'h10;
  localparam logic [7:0] REG_IDX_BASE = 8'h40;
  localparam logic [7:0] REG_MOD_BASE = 8'h80;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] LATCH_RST = 32'h0000_0000;
  localparam logic [31:0] MASKP_RST = 32'h0000_0000;
  localparam int MODE_SIMD_BIT = 0;
  localparam int MODE_BCAST_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // instruction encodings and field positions
  localparam logic [2:0] OP10_IND = 3'h6;
  localparam logic [2:0] OP10_REL = 3'h7;
  localparam logic [7:0] OP9_IND = 8'h08;
  localparam logic [7:0] OP9_REL = 8'h09;
  localparam logic [7:0] OP11_RTS = 8'h0A;
  localparam logic [7:0] OP11_RTI = 8'h0B;
  localparam int F_D = 44;
  localparam int F_DMI_LO = 41;
  localparam int F_DMM_LO = 38;
  localparam int F_B = 39;
  localparam int F_A = 38;
  localparam int F_TEST_CONDITION_CODE_LO = 33;
  localparam int F_PMI_LO = 30;
  localparam int F_PMM_LO = 27;
  localparam int F_REL_LO = 27;
  localparam int F_J = 26;
  localparam int F_E = 25;
  localparam int F_CI = 24;
  localparam int F_LR = 24;
  localparam int F_DREG_LO = 23;
  localparam int CMP_W = 23;
  localparam logic [4:0] TEST_CONDITION_CODE_ALWAYS = 5'h1F;
  // ==========================================================
  // decoded instruction group
  typedef enum logic [1:0] {
    INS_NONE = 2'b00,
    INS_T9 = 2'b01,
    INS_T10 = 2'b10,
    INS_T11 = 2'b11
  } ibr_kind_t;
endpackage : ibr_pkg

// ==== ibr_stack_model.sv ====
// ibr_stack_model: program-counter stack partner that pops on request
`timescale 1ns/1ps
`default_nettype none
module ibr_stack_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // stack port
  input wire logic pc_stack_pop,
  output logic [31:0] pc_stack_top
);
  // ==========================================
  // return addresses, one new entry per pop
  logic [1:0] ptr_r;
  assign pc_stack_top = 32'h0000_0100 + {30'h0, ptr_r};
  always_ff @(posedge aclk) begin
    if (!aresetn) ptr_r <= 2'h0;
    else if (pc_stack_pop) ptr_r <= ptr_r + 2'h1;
  end
endmodule : ibr_stack_model
`default_nettype wire

// ==== ibr_test_condition_code_eval.sv ====
// ibr_test_condition_code_eval: test-condition evaluation for one processing element
`timescale 1ns/1ps
`default_nettype none
module ibr_test_condition_code_eval
  import ibr_pkg::*;
(
  // condition select and element flags
  input wire logic [4:0] test_condition_code_code,
  input wire logic [15:0] flags,
  // result
  output logic test_condition_code_true
);
  // ==========================================================
  // code 1F is the omitted condition; bit 4 inverts the selected flag
  always_comb begin
    if (test_condition_code_code == TEST_CONDITION_CODE_ALWAYS) begin
      test_condition_code_true = 1'b1;
    end else begin
      test_condition_code_true = flags[test_condition_code_code[3:0]] ^ test_condition_code_code[4];
    end
  end
endmodule : ibr_test_condition_code_eval
`default_nettype wire
